// File: shared/cpl_pkg.sv
// ==========================================================
// Palette constants, field layouts and helpers
// ==========================================================
package cpl_pkg;

   // Table geometry
   localparam int CPL_ENTRIES     = 16;   // Palette entries
   localparam int CPL_ABITS       = 5;    // Byte address width
   localparam int CPL_FIFO_DEPTH  = 8;    // Write buffer depth
   localparam int CPL_SYNC_STAGES = 2;    // Pin synchroniser depth

   // Pin encodings
   localparam logic CPL_MODE_NONMUX = 1'b1; // Mode pin high
   localparam logic CPL_DS_SPLIT    = 1'b1; // Strobe high at latch
   localparam logic CPL_RW_READ     = 1'b1; // Direction high reads
   localparam logic CPL_AS_ADDR     = 1'b1; // Select addr register

   // Byte layout details
   localparam logic [2:0] CPL_ODD_PAD = 3'h0; // Unused upper bits
   localparam logic [4:0] CPL_ADDR_STEP = 5'h01; // Auto-increment

   // One palette entry, 13 bits
   typedef struct packed {
      logic       overlay;
      logic [3:0] third;
      logic [3:0] second;
      logic [3:0] first;
   } cpl_entry_t;

   // One buffered host write
   typedef struct packed {
      logic [CPL_ABITS-1:0] addr;
      logic [7:0]           data;
   } cpl_wr_t;

   // Host pins, carried together through the synchroniser
   typedef struct packed {
      logic       as;
      logic       ds;
      logic       rw;
      logic       csl_n;
      logic       csh;
      logic [7:0] bus;
   } cpl_hostpins_t;

   // Entry number of a byte address
   function automatic logic [3:0] cpl_entry_idx(logic [4:0] a);
      return a[4:1];
   endfunction

   // Byte as seen by the host
   function automatic logic [7:0] cpl_byte_of(cpl_entry_t e,
                                              logic odd);
      return odd ? {CPL_ODD_PAD, e.overlay, e.third}
                 : {e.second, e.first};
   endfunction

   // Entry after a host byte write; pad bits dropped
   function automatic cpl_entry_t cpl_merge(cpl_entry_t e, logic odd,
                                            logic [7:0] d);
      cpl_entry_t r;
      r = e;
      if (odd)
      begin
         r.overlay = d[4];
         r.third   = d[3:0];
      end
      else
      begin
         r.second = d[7:4];
         r.first  = d[3:0];
      end
      return r;
   endfunction

endpackage

// File: logic/cpl_sync.sv
// ==========================================================
// Multi-bit level synchroniser
// ==========================================================
module cpl_sync #(
   parameter int WIDTH  = 1,
   parameter int STAGES = 2
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // Levels in and out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   // Fewer than two flops is no synchroniser
   if (STAGES < 2)
   begin : g_bad
      $error("cpl_sync needs at least two stages");
   end

   logic [WIDTH-1:0] stage_reg [STAGES]; // Flop chain

   // Shift chain; first flop feeds only the second
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < STAGES; i++)
            stage_reg[i] <= '0;
      end
      else
      begin
         stage_reg[0] <= d;
         for (int i = 1; i < STAGES; i++)
            stage_reg[i] <= stage_reg[i-1];
      end
   end

   assign q = stage_reg[STAGES-1];

endmodule

// File: logic/cpl_fifo.sv
// ==========================================================
// Flop-based FIFO with valid/ready on both sides
// ==========================================================
module cpl_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH); // Index width

   // Pointer wrap needs a power of two
   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad
      $error("cpl_fifo depth must be a power of two, two or more");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage flops
   logic [AW:0]      wr_ptr_reg;      // Extra bit tells full
   logic [AW:0]      rd_ptr_reg;      // from empty
   logic             push;
   logic             pop;

   // Honest flags from the pointers
   assign out_valid = (wr_ptr_reg != rd_ptr_reg);
   assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

   // Storage write
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= '0;
      end
      else if (push)
      begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   // Write pointer
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         wr_ptr_reg <= '0;
      else if (push)
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
   end

   // Read pointer
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         rd_ptr_reg <= '0;
      else if (pop)
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
   end

endmodule

// File: logic/cpl_palette_top.sv
// ==========================================================
// Colour palette look-up with host port and video path
// ==========================================================

// Function
// - Sixteen entries: three nibbles plus overlay
// - Mode pin high selects non-multiplexed port
// - Non-mux: latch strobe selects register
// - Mux: latch address, strobe, selects on fall
// - Non-mux: drive and transfer while strobe high
// - Mux: latched strobe picks bus convention
// - Direction high reads, low writes
// - Selected when both selects true; mux mode checks them at latch fall
// - Mux holds latched select while strobe low
// - Dot edge registers pixel, loads outputs
// - Pixel index register picks video entry
// - Overlay output registered on dot edge
// - Colours appear one dot period later
// - Registered blanking forces outputs low
// - Reset pin blanks colours until access
// - Entry N at bytes 2N, 2N+1
// - Write-only address, read/write data register
// - Non-mux data access increments address modulo 32
// - Chip select forces outputs low
module cpl_palette_top #(
   parameter int FIFO_DEPTH = cpl_pkg::CPL_FIFO_DEPTH
) (
   // System
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // Host bus
   input  wire logic       bus_mode_select,
   input  wire logic       addr_latch_strobe,
   input  wire logic       data_strobe_in,
   input  wire logic       read_write_select,
   input  wire logic       chip_select_low_n,
   input  wire logic       chip_select_high,
   input  wire logic [7:0] addr_data_in,
   output logic      [7:0] addr_data_out,
   output logic            addr_data_oe,
   // Video input
   input  wire logic       dot_clock,
   input  wire logic [3:0] pixel_index,
   input  wire logic       blanking_in,
   input  wire logic       blank_reset_in,
   // Video output
   output logic      [3:0] color_out_a,
   output logic      [3:0] color_out_b,
   output logic      [3:0] color_out_c,
   output logic            overlay_flag
);
   import cpl_pkg::*;

   // =======================================================
   // Declarations
   // =======================================================
   cpl_hostpins_t        pins_raw;      // Pins as they arrive
   cpl_hostpins_t        pins_s;        // Synchronised pins
   cpl_hostpins_t        pins_q;        // One cycle older
   cpl_entry_t           pal_reg [CPL_ENTRIES]; // Palette table
   logic [CPL_ABITS-1:0] addr_reg;      // Host byte address
   logic                 split_reg;     // Separate-strobe bus
   logic                 sel_lat_reg;   // Select caught at latch
   logic                 nonmux;        // Port mode
   logic                 cs_live;       // Both selects true now
   logic                 selected;      // Device selected
   logic                 as_fall;       // Latch strobe fell
   logic                 ds_fall;       // Data strobe fell
   logic                 ds_rise;       // Data strobe rose
   logic                 rw_rise;       // Direction line rose
   logic                 wr_ev;         // Palette byte write
   logic                 rd_ev;         // Palette byte read done
   logic                 addr_wr_ev;    // Address register write
   logic                 pend_reg;      // Write waiting for FIFO
   cpl_wr_t              pend_word_reg; // Its address and data
   logic                 fifo_ready;    // FIFO can take a write
   logic                 drain_valid;   // Write ready to apply
   logic                 drain_ready;   // Table port free
   cpl_wr_t              drain_word;    // Write to apply
   logic                 dot_q;         // Dot clock one cycle old
   logic                 dot_rise;      // Dot clock rising edge
   logic [3:0]           idx_reg;       // Colour index register
   logic                 blank_reg;     // Registered blanking
   logic                 hold_reg;      // Reset blanking active
   cpl_entry_t           vid_entry;     // Entry at colour index
   cpl_entry_t           out_reg;       // Output registers

   // =======================================================
   // Host pin synchronisation
   // =======================================================
   assign pins_raw = {addr_latch_strobe, data_strobe_in,
                      read_write_select, chip_select_low_n,
                      chip_select_high, addr_data_in};

   // Data bus rides with the strobes, so both line up
   cpl_sync #(
      .WIDTH  ($bits(cpl_hostpins_t)),
      .STAGES (CPL_SYNC_STAGES)
   ) u_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d       (pins_raw),
      .q       (pins_s)
   );

   // Delayed copy for edge detection
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         pins_q <= '0;
      else
         pins_q <= pins_s;
   end

   // =======================================================
   // Selection and access decode
   // =======================================================
   assign nonmux  = (bus_mode_select == CPL_MODE_NONMUX);
   assign as_fall = pins_q.as && !pins_s.as;
   assign ds_fall = pins_q.ds && !pins_s.ds;
   assign ds_rise = !pins_q.ds && pins_s.ds;
   assign rw_rise = !pins_q.rw && pins_s.rw;
   assign cs_live = !pins_s.csl_n && pins_s.csh;

   // Mux mode keeps its latched select only while strobe low
   assign selected = nonmux ? cs_live
                            : (sel_lat_reg && !pins_s.as);

   // Access events close at the end of each strobe
   always_comb
   begin
      wr_ev      = 1'b0;
      rd_ev      = 1'b0;
      addr_wr_ev = 1'b0;
      addr_data_oe = 1'b0;
      if (!selected)
      begin
         // Unselected: bus ignored
      end
      else if (nonmux)
      begin
         // Strobe high marks the transfer window
         addr_data_oe = pins_s.ds && (pins_s.rw == CPL_RW_READ) &&
                        (pins_s.as != CPL_AS_ADDR);
         addr_wr_ev = ds_fall && (pins_q.as == CPL_AS_ADDR) &&
                      (pins_q.rw != CPL_RW_READ);
         wr_ev = ds_fall && (pins_q.as != CPL_AS_ADDR) &&
                 (pins_q.rw != CPL_RW_READ);
         rd_ev = ds_fall && (pins_q.as != CPL_AS_ADDR) &&
                 (pins_q.rw == CPL_RW_READ);
      end
      else if (split_reg == CPL_DS_SPLIT)
      begin
         // Read strobe low reads; write strobe rising ends it
         addr_data_oe = !pins_s.ds;
         wr_ev = rw_rise;
         rd_ev = ds_rise;
      end
      else
      begin
         // Combined strobe with a direction line
         addr_data_oe = pins_s.ds && (pins_s.rw == CPL_RW_READ);
         wr_ev = ds_fall && (pins_q.rw != CPL_RW_READ);
         rd_ev = ds_fall && (pins_q.rw == CPL_RW_READ);
      end
   end

   // Bus convention and select caught at latch fall
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         split_reg   <= 1'b0;
         sel_lat_reg <= 1'b0;
      end
      else if (!nonmux && as_fall)
      begin
         split_reg   <= pins_s.ds;
         sel_lat_reg <= cs_live;
      end
   end

   // Address register: latched, written, or stepped
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         addr_reg <= '0;
      else if (!nonmux && as_fall)
         addr_reg <= pins_s.bus[CPL_ABITS-1:0];
      else if (nonmux && addr_wr_ev)
         addr_reg <= pins_q.bus[CPL_ABITS-1:0];
      else if (nonmux && (wr_ev || rd_ev))
         addr_reg <= addr_reg + CPL_ADDR_STEP;
   end

   // Read data follows the addressed byte every cycle
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         addr_data_out <= '0;
      else
         addr_data_out <= cpl_byte_of(pal_reg[cpl_entry_idx(addr_reg)],
                                      addr_reg[0]);
   end

   // =======================================================
   // Write buffering
   // =======================================================
   // A write waits here if the FIFO is full; a second one
   // arriving before it drains replaces it
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pend_reg      <= 1'b0;
         pend_word_reg <= '0;
      end
      else if (wr_ev)
      begin
         pend_reg      <= 1'b1; // New write wins over the hand-off
         pend_word_reg <= {addr_reg, pins_q.bus};
      end
      else if (fifo_ready)
      begin
         pend_reg <= 1'b0;
      end
   end

   // Video fetch owns the table on dot edges, so drain stalls
   assign drain_ready = !dot_rise;

   cpl_fifo #(
      .WIDTH ($bits(cpl_wr_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_valid  (pend_reg),
      .in_ready  (fifo_ready),
      .in_data   (pend_word_reg),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_word)
   );

   // =======================================================
   // Palette storage
   // =======================================================
   // Byte write merges into the entry; pad bits dropped
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < CPL_ENTRIES; i++)
            pal_reg[i] <= '0;
      end
      else if (drain_valid && drain_ready)
      begin
         pal_reg[cpl_entry_idx(drain_word.addr)] <=
            cpl_merge(pal_reg[cpl_entry_idx(drain_word.addr)],
                      drain_word.addr[0], drain_word.data);
      end
   end

   // =======================================================
   // Video path
   // =======================================================
   assign dot_rise  = dot_clock && !dot_q;
   assign vid_entry = pal_reg[idx_reg];

   // Dot clock edge detector
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         dot_q <= 1'b0;
      else
         dot_q <= dot_clock;
   end

   // Pixel and blanking capture
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         idx_reg   <= '0;
         blank_reg <= 1'b0;
      end
      else if (dot_rise)
      begin
         idx_reg   <= pixel_index;
         blank_reg <= blanking_in;
      end
   end

   // Reset blanking: pin sets it, host access ends it
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         hold_reg <= 1'b0;
      else if (blank_reset_in)
         hold_reg <= 1'b1;
      else if (wr_ev || rd_ev || addr_wr_ev)
         hold_reg <= 1'b0;
   end

   // Output registers; select and reset forcing act at once, blanking on dot edge
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         out_reg <= '0;
      else if (selected || hold_reg || blank_reset_in)
         out_reg <= '0;
      else if (dot_rise && blank_reg)
         out_reg <= '0;
      else if (dot_rise)
         out_reg <= vid_entry;
   end

   assign color_out_a  = out_reg.first;
   assign color_out_b  = out_reg.second;
   assign color_out_c  = out_reg.third;
   assign overlay_flag = out_reg.overlay;

   // =======================================================
   // Assertions
   // =======================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_oe_strobe;
      nonmux && addr_data_oe |-> pins_s.ds && !pins_s.as;
   endproperty
   a_oe_strobe: assert property (p_oe_strobe)
      else $error("bus driven outside strobe");

   property p_unsel_quiet;
      nonmux && !cs_live |-> !addr_data_oe && !wr_ev;
   endproperty
   a_unsel_quiet: assert property (p_unsel_quiet)
      else $error("access while not selected");

   property p_select_blanks;
      selected ##1 selected |-> out_reg == '0;
   endproperty
   a_select_blanks: assert property (p_select_blanks)
      else $error("outputs live during select");

   property p_reset_blanks;
      blank_reset_in |=> (out_reg == '0) && hold_reg;
   endproperty
   a_reset_blanks: assert property (p_reset_blanks)
      else $error("reset pin did not blank outputs");

   property p_incr;
      nonmux && (wr_ev || rd_ev) |=>
         addr_reg == $past(addr_reg) + CPL_ADDR_STEP;
   endproperty
   a_incr: assert property (p_incr)
      else $error("address did not step");

   property p_entry_out;
      dot_rise && !blank_reg && !selected && !hold_reg &&
         !blank_reset_in |=> out_reg == $past(vid_entry);
   endproperty
   a_entry_out: assert property (p_entry_out)
      else $error("wrong entry on outputs");

   property p_blank_out;
      dot_rise && blank_reg |=> out_reg == '0;
   endproperty
   a_blank_out: assert property (p_blank_out)
      else $error("blanking not applied");

   property p_latch_addr;
      !nonmux && as_fall |=>
         addr_reg == $past(pins_s.bus[CPL_ABITS-1:0]);
   endproperty
   a_latch_addr: assert property (p_latch_addr)
      else $error("address not latched on strobe fall");

   property p_pad_zero;
      $past(addr_reg[0]) |-> addr_data_out[7:5] == CPL_ODD_PAD;
   endproperty
   a_pad_zero: assert property (p_pad_zero)
      else $error("pad bits not zero");

   property p_index;
      dot_rise |=> idx_reg == $past(pixel_index);
   endproperty
   a_index: assert property (p_index)
      else $error("pixel index not captured");

endmodule

// File: bench/cpl_video_src.sv
// ====================
// Display controller stand-in
// ====================
module cpl_video_src (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // Wanted pixel
   input  wire logic [3:0] pix_want,
   input  wire logic       blank_want,
   // Pixel stream out
   output logic            dot_clock,
   output logic      [3:0] pixel_index,
   output logic            blanking_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] div_reg;   // Half-period counter

   // Dot clock at 1/8 of system rate; slow so each edge is seen
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         div_reg     <= 2'h0;
         dot_clock   <= 1'b0;
         pixel_index <= 4'h0;
         blanking_in <= 1'b0;
      end
      else
      begin
         div_reg <= div_reg + 2'h1;
         if (div_reg == 2'h3)
         begin
            dot_clock <= ~dot_clock;
            // Change on the fall keeps setup ahead of the rise
            if (dot_clock)
            begin
               pixel_index <= pix_want;
               blanking_in <= blank_want;
            end
         end
      end
   end
endmodule

// File: bench/tb_color_palette_lookup.sv
// ====================
// Palette bench
// ====================
module tb_color_palette_lookup;
   timeunit 1ns;
   timeprecision 1ps;
   import cpl_pkg::*;

   logic        clk_sys, rstn, mode_pin, as_pin, ds_pin, rw_pin;
   logic        csl_n, csh, blank_rst, blank_want, sel_ok;
   logic  [7:0] bus_in, bus_out;
   logic        oe, dot_clk, blank_pin, ov_out;
   logic  [3:0] pix_want, pix_pin, ca, cb, cc;
   logic [12:0] shown;         // Outputs packed as an entry
   cpl_entry_t  exp_tab [16];  // Expected table contents
   int          err_total, check_count;

   assign shown = {ov_out, cc, cb, ca};

   cpl_palette_top DUT (
      .clk_sys(clk_sys), .rstn(rstn), .bus_mode_select(mode_pin),
      .addr_latch_strobe(as_pin), .data_strobe_in(ds_pin),
      .read_write_select(rw_pin), .chip_select_low_n(csl_n),
      .chip_select_high(csh), .addr_data_in(bus_in),
      .addr_data_out(bus_out), .addr_data_oe(oe), .dot_clock(dot_clk),
      .pixel_index(pix_pin), .blanking_in(blank_pin),
      .blank_reset_in(blank_rst), .color_out_a(ca), .color_out_b(cb),
      .color_out_c(cc), .overlay_flag(ov_out));

   cpl_video_src VID (
      .clk_sys(clk_sys), .rstn(rstn), .pix_want(pix_want),
      .blank_want(blank_want), .dot_clock(dot_clk),
      .pixel_index(pix_pin), .blanking_in(blank_pin));

   // 200 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] want);
      check_count++;
      if (got !== want)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask

   task automatic chk13(input logic [12:0] got, input logic [12:0] want);
      check_count++;
      if (got !== want)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask

   // Host view of byte a of the expected table
   function automatic logic [7:0] byte_of(input int a);
      cpl_entry_t e;
      e = exp_tab[a/2];
      return a[0] ? {3'h0, e.overlay, e.third} : {e.second, e.first};
   endfunction

   // Non-multiplexed access; strobe phases outlast the synchroniser
   task automatic nm_acc(input logic as_v, input logic rd,
                         input logic [7:0] d, input logic [7:0] want);
      @(posedge clk_sys);
      as_pin <= as_v;
      rw_pin <= rd;
      bus_in <= d;
      csl_n  <= 1'b0;
      csh    <= sel_ok;
      ds_pin <= 1'b1;
      tick(5);
      if (rd)
      begin
         chk8({7'h0, oe}, {7'h0, sel_ok});
         if (sel_ok)
         begin
            chk8(bus_out, want);
            chk13(shown, 13'h0);
         end
      end
      ds_pin <= 1'b0;
      tick(4);
      csl_n <= 1'b1;
      csh   <= 1'b0;
      tick(1);
   endtask

   // Multiplexed access; idle strobe level names the convention
   task automatic mx_acc(input logic sep, input logic rd,
                         input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] want);
      @(posedge clk_sys);
      as_pin <= 1'b1;
      bus_in <= a;
      ds_pin <= sep;
      rw_pin <= sep | rd;
      csl_n  <= 1'b0;
      csh    <= 1'b1;
      tick(4);
      as_pin <= 1'b0;
      tick(4);
      // Selects dropped: the latched selection must carry on
      csl_n  <= 1'b1;
      csh    <= 1'b0;
      bus_in <= d;
      if (!sep)
         ds_pin <= 1'b1;
      else if (rd)
         ds_pin <= 1'b0;
      else
         rw_pin <= 1'b0;
      tick(5);
      if (rd)
      begin
         chk8(bus_out, want);
         chk8({7'h0, oe}, 8'h01);
      end
      ds_pin <= sep;
      rw_pin <= sep | rd;
      tick(4);
      as_pin <= 1'b1;
      tick(4);
   endtask

   // Present a pixel and look at the outputs a few dot periods on
   task automatic show(input logic [3:0] p, input logic b,
                       input logic [12:0] want);
      pix_want   <= p;
      blank_want <= b;
      tick(40);
      chk13(shown, want);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog: the tests need well under 10 us
   initial
   begin
      #100us;
      err_total++;
      test_done;
   end

   initial
   begin
      {rstn, as_pin, ds_pin, csh, blank_rst, blank_want} = 6'h00;
      {mode_pin, rw_pin, csl_n, sel_ok} = 4'hF;
      bus_in      = 8'h00;
      pix_want    = 4'h0;
      err_total   = 0;
      check_count = 0;
      for (int i = 0; i < 16; i++)
         exp_tab[i] = {i[0], i[3:0] + 4'h3, ~i[3:0], i[3:0]};
      tick(3);
      rstn <= 1'b1;
      tick(4);
      chk13(shown, 13'h0);
      // Load whole table, pad bits set on odd bytes
      nm_acc(1'b1, 1'b0, 8'h00, 8'h00);
      for (int a = 0; a < 32; a++)
         nm_acc(1'b0, 1'b0, byte_of(a) | (a[0] ? 8'hE0 : 8'h00), 8'h00);
      // Address has wrapped to zero: read all back
      for (int a = 0; a < 32; a++)
         nm_acc(1'b0, 1'b1, 8'h5A, byte_of(a));
      $display("test load done");
      for (int p = 0; p < 16; p += 5)
         show(p[3:0], 1'b0, exp_tab[p]);
      show(4'hF, 1'b1, 13'h0);
      $display("test video done");
      // Deselected accesses change nothing
      sel_ok = 1'b0;
      nm_acc(1'b1, 1'b0, 8'h02, 8'h00);
      nm_acc(1'b0, 1'b0, 8'hFF, 8'h00);
      nm_acc(1'b0, 1'b1, 8'h00, 8'h00);
      sel_ok = 1'b1;
      nm_acc(1'b1, 1'b0, 8'h02, 8'h00);
      nm_acc(1'b0, 1'b1, 8'h00, byte_of(2));
      $display("test select done");
      mode_pin <= 1'b0;
      exp_tab[2] = 13'h1CA5;
      mx_acc(1'b0, 1'b0, 8'h04, 8'hA5, 8'h00);
      mx_acc(1'b0, 1'b1, 8'h04, 8'hFB, 8'hA5);
      mx_acc(1'b1, 1'b0, 8'h05, 8'h1C, 8'h00);
      mx_acc(1'b1, 1'b1, 8'h05, 8'hFA, 8'h1C);
      mode_pin <= 1'b1;
      show(4'h2, 1'b0, exp_tab[2]);
      $display("test mux done");
      // Reset blanking holds until a host access
      blank_rst <= 1'b1;
      tick(4);
      blank_rst <= 1'b0;
      show(4'h2, 1'b0, 13'h0);
      nm_acc(1'b1, 1'b0, 8'h00, 8'h00);
      show(4'h2, 1'b0, exp_tab[2]);
      $display("test reset blank done");
      test_done;
   end
endmodule
